// ==== verilog/vcw_params.svh ====
// Purpose: Register map, field positions and reset values of the capture window block
// Assumes: 12-bit byte address on the register port
// Notes: Field positions are bit indices of a 32-bit register word
`ifndef VCW_PARAMS_SVH
`define VCW_PARAMS_SVH

// ==========================================================
// Register offsets
`define VCW_OFF_CTRL 12'h1C0
`define VCW_OFF_XWIN 12'h1C4
`define VCW_OFF_YWIN 12'h1C8
`define VCW_OFF_SIZE 12'h1CC
`define VCW_OFF_FB0 12'h1D0
`define VCW_OFF_FB1 12'h1D4
`define VCW_OFF_TEST 12'h1D8
`define VCW_OFF_TDATA 12'h1DC
`define VCW_OFF_IRQ 12'h1E0
`define VCW_OFF_ICLR 12'h1E4

// ==========================================================
// Field positions
`define VCW_LO_FIRST 4
`define VCW_LO_LAST 20
`define VCW_LO_STRAP 0
`define VCW_BIT_TME 11
`define VCW_LO_TSEL 12
`define VCW_LO_TDATA 16
`define VCW_LO_IEN 20
`define VCW_LO_IFLG 28
`define VCW_LO_THR 3
`define VCW_BIT_DBE 24
`define VCW_BIT_DBS 25
`define VCW_BIT_HSP 28
`define VCW_BIT_VSP 29
`define VCW_BIT_SKIP 30
`define VCW_BIT_CEN 31

// ==========================================================
// Reset values and write masks
`define VCW_CTRL_RST 32'h000000C0
`define VCW_CTRL_WMASK 32'hF10000F8
`define VCW_XWIN_WMASK 32'hFFF0FFF0
`define VCW_YWIN_WMASK 32'h7FF07FF0
`define VCW_FB_WMASK 32'hFFFFFFFC
`define VCW_TEST_WMASK 32'h0000F800
`define VCW_IEN_RST 4'h0
`define VCW_IFLG_RST 4'h0

// ==========================================================
// Counter test select codes
`define VCW_TSEL_HCNT 4'h1
`define VCW_TSEL_VCNT 4'h2
`define VCW_TSEL_HACC 4'h4
`define VCW_TSEL_VACC 4'h8

// Strap pins are latched once the synchroniser has settled
`define VCW_STRAP_WAIT 2'h2

`endif

// ==== verilog/vcw_pkg.sv ====
// Purpose: Types shared by the capture window block
// Assumes: Nothing beyond the parameter header
// Notes: Pixel pins travel together through the synchroniser
package vcw_pkg;

   // ==========================================================
   // Pin group from the video source
   typedef struct packed {
      logic vclk;
      logic hs;
      logic vs;
      logic [7:0] data;
   } vcw_pins_type;

   // ==========================================================
   // Capture sequencing
   typedef enum logic [1:0] {
      VCW_IDLE = 2'b00,
      VCW_RUN = 2'b01,
      VCW_FLUSH = 2'b10
   } vcw_state_type;

endpackage

// ==== verilog/vcw_capture.sv ====
// Purpose: Video capture crop, down-scale, frame buffer addressing, test and interrupts
// Assumes: Video pins come from another clock domain; pixel clock far slower than clk
// Notes: Capture buffer depth must be a power of two
`timescale 1ns/1ns
`include "vcw_params.svh"

module vcw_capture #(
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Video source pins
   input wire logic vid_clk,
   input wire logic vertical_sync_in,
   input wire logic horizontal_sync_in,
   input wire logic [7:0] vid_data,
   input wire logic [3:0] strap_data_pins,
   // Event pulses from neighbouring units
   input wire logic filter_done,
   input wire logic out_vsync,
   // Memory write port
   output logic mem_req,
   output logic mem_valid,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_data,
   input wire logic mem_ack,
   // Interrupt
   output logic irq
);
   import vcw_pkg::*;

   localparam int PW = $clog2(DEPTH);

   // ==========================================================
   // Helpers
   function automatic logic in_rng(input logic [12:0] v, input logic [12:0] lo,
                                   input logic [12:0] hi);
      in_rng = (v >= lo) && (v <= hi);
   endfunction

   // Returns keep bit over next accumulator; no reduction passes every item
   function automatic logic [13:0] dda(input logic [12:0] acc, input logic [12:0] outn,
                                       input logic [12:0] src);
      logic [12:0] sum;
      sum = acc + outn;
      if (outn >= src) begin
         dda = {1'b1, acc};
      end else if (sum >= src) begin
         dda = {1'b1, 13'(sum - src)};
      end else begin
         dda = {1'b0, sum};
      end
   endfunction

   // ==========================================================
   // Pin synchroniser
   vcw_pins_type pins_s1_q, pins_s2_q;
   logic [3:0] strap_s1_q, strap_s2_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pins_s1_q <= '0;
         pins_s2_q <= '0;
         strap_s1_q <= 4'h0;
         strap_s2_q <= 4'h0;
      end else begin
         pins_s1_q <= {vid_clk, horizontal_sync_in, vertical_sync_in, vid_data};
         pins_s2_q <= pins_s1_q;
         strap_s1_q <= strap_data_pins;
         strap_s2_q <= strap_s1_q;
      end
   end

   // ==========================================================
   // Core state
   logic [31:0] ctrl_q, ctrl_d, xwin_q, xwin_d, ywin_q, ywin_d, size_q, size_d;
   logic [31:0] fb0_q, fb0_d, fb1_q, fb1_d, test_q, test_d, rdata_q, rdata_d;
   logic [3:0] strap_q, strap_d, ien_q, ien_d, iflg_q, iflg_d;
   logic [1:0] strap_cnt_q, strap_cnt_d, bcnt_q, bcnt_d;
   logic irq_q, irq_d, vclk_prev_q, vclk_prev_d, hs_prev_q, hs_prev_d;
   logic vs_prev_q, vs_prev_d, keep_line_q, keep_line_d, field_q, field_d;
   logic buf_sel_q, buf_sel_d, req_q, req_d, valid_q, valid_d;
   logic [12:0] hcnt_q, hcnt_d, vcnt_q, vcnt_d, hacc_q, hacc_d, vacc_q, vacc_d;
   logic [29:0] addr_q, addr_d;
   logic [31:0] word_q, word_d, mdata_q, mdata_d;
   logic [PW-1:0] wptr_q, wptr_d, rptr_q, rptr_d, tidx_q, tidx_d;
   logic [PW:0] count_q, count_d;
   logic [31:0] buf_q [DEPTH];
   logic [31:0] buf_d [DEPTH];
   vcw_state_type state_q, state_d;

   // Combinational scratch
   logic capture_test_enable, pix_edge, hs_act, vs_act, hs_end, vs_end, push, pop, frame_ok;
   logic [13:0] step;
   logic [12:0] xsrc, ysrc;
   logic [15:0] tdata;
   logic [31:0] push_word, rd_val;
   logic [3:0] ev;

   always_comb begin
      ctrl_d = ctrl_q;
      xwin_d = xwin_q;
      ywin_d = ywin_q;
      size_d = size_q;
      fb0_d = fb0_q;
      fb1_d = fb1_q;
      test_d = test_q;
      strap_d = strap_q;
      strap_cnt_d = strap_cnt_q;
      ien_d = ien_q;
      bcnt_d = bcnt_q;
      hcnt_d = hcnt_q;
      vcnt_d = vcnt_q;
      hacc_d = hacc_q;
      vacc_d = vacc_q;
      keep_line_d = keep_line_q;
      field_d = field_q;
      buf_sel_d = buf_sel_q;
      addr_d = addr_q;
      word_d = word_q;
      wptr_d = wptr_q;
      rptr_d = rptr_q;
      tidx_d = tidx_q;
      buf_d = buf_q;
      state_d = state_q;
      push = 1'b0;
      push_word = word_q;
      ev = 4'h0;
      step = 14'h0000;
      frame_ok = 1'b0;
      capture_test_enable = test_q[`VCW_BIT_TME];
      // Polarity bit set means active high; sync ends wait until pin levels are settled
      hs_act = ~(pins_s2_q.hs ^ ctrl_q[`VCW_BIT_HSP]);
      vs_act = ~(pins_s2_q.vs ^ ctrl_q[`VCW_BIT_VSP]);
      hs_end = hs_prev_q & ~hs_act & (strap_cnt_q == 2'h3);
      vs_end = vs_prev_q & ~vs_act & (strap_cnt_q == 2'h3);
      pix_edge = pins_s2_q.vclk & ~vclk_prev_q;
      vclk_prev_d = pins_s2_q.vclk;
      hs_prev_d = hs_act;
      vs_prev_d = vs_act;
      xsrc = 13'(xwin_q[`VCW_LO_LAST +: 12]) - 13'(xwin_q[`VCW_LO_FIRST +: 12]) + 13'h0001;
      ysrc = 13'(ywin_q[`VCW_LO_LAST +: 11]) - 13'(ywin_q[`VCW_LO_FIRST +: 11]) + 13'h0001;

      // Strap level is caught only after the synchroniser holds real pin values
      if (strap_cnt_q == `VCW_STRAP_WAIT) begin
         strap_d = strap_s2_q;
      end
      if (strap_cnt_q != 2'h3) begin
         strap_cnt_d = strap_cnt_q + 2'h1;
      end

      // Frame start at the end of vertical sync
      if (vs_end) begin
         ev[1] = 1'b1;
         vcnt_d = 13'h0000;
         vacc_d = 13'h0000;
         keep_line_d = 1'b0;
         field_d = ~field_q;
         frame_ok = ~ctrl_q[`VCW_BIT_SKIP] | ~field_q;
         if (state_q == VCW_RUN) begin
            state_d = VCW_FLUSH;
         end else if (state_q == VCW_IDLE && ctrl_q[`VCW_BIT_CEN] && frame_ok && !capture_test_enable) begin
            state_d = VCW_RUN;
            word_d = 32'h00000000;
            bcnt_d = 2'h0;
            addr_d = buf_sel_q ? fb1_q[31:2] : fb0_q[31:2];
         end
      end else if (hs_end) begin
         // New line: count lines from sync end and decide if it survives scaling
         hcnt_d = 13'h0000;
         hacc_d = 13'h0000;
         if (vcnt_q != 13'h1FFF) begin
            vcnt_d = vcnt_q + 13'h0001;
         end
         if (in_rng(vcnt_d, 13'(ywin_q[`VCW_LO_FIRST +: 11]),
                    13'(ywin_q[`VCW_LO_LAST +: 11]))) begin
            step = dda(vacc_q, 13'(size_q[`VCW_LO_FIRST +: 11]), ysrc);
            keep_line_d = step[13];
            vacc_d = step[12:0];
         end else begin
            keep_line_d = 1'b0;
         end
         if (state_q == VCW_RUN && vcnt_q == 13'(ywin_q[`VCW_LO_LAST +: 11])) begin
            state_d = VCW_FLUSH;
         end
      end else if (pix_edge && !hs_act) begin
         if (state_q == VCW_RUN && keep_line_q && !capture_test_enable &&
             in_rng(hcnt_q, 13'(xwin_q[`VCW_LO_FIRST +: 12]),
                    13'(xwin_q[`VCW_LO_LAST +: 12]))) begin
            step = dda(hacc_q, 13'(size_q[`VCW_LO_LAST +: 11]), xsrc);
            hacc_d = step[12:0];
            if (step[13]) begin
               word_d[8*bcnt_q +: 8] = pins_s2_q.data;
               bcnt_d = bcnt_q + 2'h1;
               push = (bcnt_q == 2'h3);
               push_word = word_d;
            end
         end
         if (hcnt_q != 13'h1FFF) begin
            hcnt_d = hcnt_q + 13'h0001;
         end
      end

      // Last word of a frame may be partly filled
      if (state_q == VCW_FLUSH && !vs_end && !hs_end) begin
         if (bcnt_q != 2'h0) begin
            push = 1'b1;
            bcnt_d = 2'h0;
         end else if (count_q == '0) begin
            ev[3] = 1'b1;
            state_d = VCW_IDLE;
            if (ctrl_q[`VCW_BIT_DBE]) begin
               buf_sel_d = ~buf_sel_q;
            end
         end
      end

      // Capture buffer fill and drain; a full buffer drops the word
      if (push && count_q == DEPTH[PW:0]) begin
         push = 1'b0;
      end
      if (push) begin
         buf_d[wptr_q] = push_word;
         wptr_d = wptr_q + 1'b1;
      end
      pop = mem_ack & valid_q & ~capture_test_enable;
      if (pop) begin
         rptr_d = rptr_q + 1'b1;
         addr_d = addr_d + 30'h00000001;
      end
      count_d = count_q + (PW+1)'(push) - (PW+1)'(pop);
      valid_d = (count_d != '0) & ~capture_test_enable;
      mdata_d = buf_d[rptr_d];
      req_d = valid_d && ((32'(count_d) >= 32'(ctrl_q[`VCW_LO_THR +: 5])) ||
                          state_d == VCW_FLUSH);

      // Counter under test
      case (test_q[`VCW_LO_TSEL +: 4])
         `VCW_TSEL_HCNT: tdata = 16'(hcnt_q);
         `VCW_TSEL_VCNT: tdata = 16'(vcnt_q);
         `VCW_TSEL_HACC: tdata = 16'(hacc_q);
         `VCW_TSEL_VACC: tdata = 16'(vacc_q);
         default: tdata = 16'h0000;
      endcase
      if (!capture_test_enable) begin
         tdata = 16'h0000;
      end

      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            `VCW_OFF_CTRL: ctrl_d = reg_wdata & `VCW_CTRL_WMASK;
            `VCW_OFF_XWIN: xwin_d = reg_wdata & `VCW_XWIN_WMASK;
            `VCW_OFF_YWIN: ywin_d = reg_wdata & `VCW_YWIN_WMASK;
            `VCW_OFF_SIZE: size_d = reg_wdata & `VCW_YWIN_WMASK;
            `VCW_OFF_FB0: fb0_d = reg_wdata & `VCW_FB_WMASK;
            `VCW_OFF_FB1: fb1_d = reg_wdata & `VCW_FB_WMASK;
            `VCW_OFF_TEST: test_d = reg_wdata & `VCW_TEST_WMASK;
            `VCW_OFF_TDATA: begin
               if (capture_test_enable) begin
                  buf_d[tidx_q] = reg_wdata;
                  tidx_d = tidx_q + 1'b1;
               end
            end
            `VCW_OFF_IRQ: ien_d = reg_wdata[`VCW_LO_IEN +: 4];
            default: ien_d = ien_q;
         endcase
      end

      // Register reads, data presented one cycle later
      case (reg_addr)
         `VCW_OFF_CTRL: rd_val = {ctrl_q[31:26], buf_sel_q, ctrl_q[24:0]};
         `VCW_OFF_XWIN: rd_val = xwin_q;
         `VCW_OFF_YWIN: rd_val = ywin_q;
         `VCW_OFF_SIZE: rd_val = size_q;
         `VCW_OFF_FB0: rd_val = fb0_q;
         `VCW_OFF_FB1: rd_val = fb1_q;
         `VCW_OFF_TEST: rd_val = {tdata, test_q[15:4], strap_q};
         `VCW_OFF_TDATA: rd_val = capture_test_enable ? buf_q[tidx_q] : 32'h00000000;
         `VCW_OFF_IRQ: rd_val = {iflg_q, 4'h0, ien_q, 20'h00000};
         default: rd_val = 32'h00000000;
      endcase
      rdata_d = reg_rd ? rd_val : 32'h00000000;
      if (reg_rd && capture_test_enable && reg_addr == `VCW_OFF_TDATA) begin
         tidx_d = tidx_q + 1'b1;
      end

      // Flags: write one to clear, a new event in the same cycle wins
      ev[0] = filter_done;
      ev[2] = out_vsync;
      iflg_d = iflg_q;
      if (reg_wr && (reg_addr == `VCW_OFF_IRQ || reg_addr == `VCW_OFF_ICLR)) begin
         iflg_d = iflg_q & ~reg_wdata[`VCW_LO_IFLG +: 4];
      end
      iflg_d = iflg_d | ev;
      irq_d = |(iflg_d & ien_d);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `VCW_CTRL_RST;
         xwin_q <= 32'h00000000;
         ywin_q <= 32'h00000000;
         size_q <= 32'h00000000;
         fb0_q <= 32'h00000000;
         fb1_q <= 32'h00000000;
         test_q <= 32'h00000000;
         rdata_q <= 32'h00000000;
         strap_q <= 4'h0;
         strap_cnt_q <= 2'h0;
         ien_q <= `VCW_IEN_RST;
         iflg_q <= `VCW_IFLG_RST;
         irq_q <= 1'b0;
         vclk_prev_q <= 1'b0;
         hs_prev_q <= 1'b0;
         vs_prev_q <= 1'b0;
         keep_line_q <= 1'b0;
         field_q <= 1'b0;
         buf_sel_q <= 1'b0;
         req_q <= 1'b0;
         valid_q <= 1'b0;
         hcnt_q <= 13'h0000;
         vcnt_q <= 13'h0000;
         hacc_q <= 13'h0000;
         vacc_q <= 13'h0000;
         addr_q <= 30'h00000000;
         word_q <= 32'h00000000;
         mdata_q <= 32'h00000000;
         bcnt_q <= 2'h0;
         wptr_q <= '0;
         rptr_q <= '0;
         tidx_q <= '0;
         count_q <= '0;
         state_q <= VCW_IDLE;
      end else begin
         ctrl_q <= ctrl_d;
         xwin_q <= xwin_d;
         ywin_q <= ywin_d;
         size_q <= size_d;
         fb0_q <= fb0_d;
         fb1_q <= fb1_d;
         test_q <= test_d;
         rdata_q <= rdata_d;
         strap_q <= strap_d;
         strap_cnt_q <= strap_cnt_d;
         ien_q <= ien_d;
         iflg_q <= iflg_d;
         irq_q <= irq_d;
         vclk_prev_q <= vclk_prev_d;
         hs_prev_q <= hs_prev_d;
         vs_prev_q <= vs_prev_d;
         keep_line_q <= keep_line_d;
         field_q <= field_d;
         buf_sel_q <= buf_sel_d;
         req_q <= req_d;
         valid_q <= valid_d;
         hcnt_q <= hcnt_d;
         vcnt_q <= vcnt_d;
         hacc_q <= hacc_d;
         vacc_q <= vacc_d;
         addr_q <= addr_d;
         word_q <= word_d;
         mdata_q <= mdata_d;
         bcnt_q <= bcnt_d;
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         tidx_q <= tidx_d;
         count_q <= count_d;
         state_q <= state_d;
      end
   end

   // ==========================================================
   // Capture storage; data words need no reset
   always_ff @(posedge clk) begin
      buf_q <= buf_d;
   end

   // ==========================================================
   // Outputs
   assign reg_rdata = rdata_q;
   assign irq = irq_q;
   assign mem_req = req_q;
   assign mem_valid = valid_q;
   assign mem_addr = {addr_q, 2'b00};
   assign mem_data = mdata_q;

endmodule

// ==== sim/vcw_src_model.sv ====
// Purpose: Video source driving pixel clock, syncs and pixel bytes
// Assumes: Syncs active low, as the block has them after reset
// Notes: Pixel clock stands still between frames
`timescale 1ns/1ns
module vcw_src_model (
   // Video pins
   output logic vclk,
   output logic vs,
   output logic hs,
   output logic [7:0] dat
);
   initial begin
      vclk = 1'b0;
      vs = 1'b1;
      hs = 1'b1;
      dat = 8'h3C;
   end

   // ==========================================================
   // Data moves with the clock low, half a period clear of the sampling edge
   task automatic tick(input logic [7:0] d);
      dat = d;
      #160 vclk = 1'b1;
      #160 vclk = 1'b0;
   endtask

   // Sync pulse, lines of pixels, then a blank line closing the last one
   task automatic frame(input int nl, input int np, input logic [7:0] sd);
      vs = 1'b0;
      tick(~dat);
      tick(~dat);
      vs = 1'b1;
      for (int l = 1; l <= nl + 1; l++) begin
         hs = 1'b0;
         tick(~dat);
         tick(~dat);
         hs = 1'b1;
         for (int p = 0; p < np && l <= nl; p++) begin
            tick(sd + 8'(l * 16 + p));
         end
      end
      dat = ~dat;
   endtask
endmodule

// ==== sim/vcw_capture_chk.sv ====
// Purpose: Port assertions of the capture window block
// Assumes: One clock domain, reset asynchronous and active high
// Notes: Mirrors follow software writes, so they see what the block sees
`timescale 1ns/1ns
`include "vcw_params.svh"
module vcw_capture_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Straps, memory and interrupt
   input wire logic [3:0] strap_data_pins,
   input wire logic mem_req,
   input wire logic mem_valid,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_data,
   input wire logic mem_ack,
   input wire logic irq
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   // ==========================================================
   // Mirrors of test enable, interrupt enables and request threshold
   logic tme_q;
   logic tme_d;
   logic [3:0] ien_q;
   logic [3:0] ien_d;
   logic [4:0] thr_q;
   logic [4:0] thr_d;
   always_comb begin
      tme_d = tme_q;
      ien_d = ien_q;
      thr_d = thr_q;
      if (reg_wr && reg_addr == `VCW_OFF_CTRL) begin
         thr_d = reg_wdata[`VCW_LO_THR +: 5];
      end
      if (reg_wr && reg_addr == `VCW_OFF_TEST) begin
         tme_d = reg_wdata[`VCW_BIT_TME];
      end
      if (reg_wr && reg_addr == `VCW_OFF_IRQ) begin
         ien_d = reg_wdata[23:20];
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tme_q <= 1'b0;
         ien_q <= 4'h0;
         thr_q <= 5'(`VCW_CTRL_RST >> `VCW_LO_THR);
      end else begin
         tme_q <= tme_d;
         ien_q <= ien_d;
         thr_q <= thr_d;
      end
   end

   // ==========================================================
   // Assertions; irq is registered from the next enables, so it changes in the same cycle as them
   a_irq_needs_enable: assert property (
      irq |-> (ien_q | $past(ien_q)) != 4'h0) else $error("irq with no enable set");
   a_strap_readback: assert property (
      reg_rd && reg_addr == `VCW_OFF_TEST |=> reg_rdata[3:0] == strap_data_pins)
      else $error("strap bits differ from pins");
   a_counter_zero_off: assert property (
      reg_rd && reg_addr == `VCW_OFF_TEST && !tme_q |=> reg_rdata[31:16] == 16'h0)
      else $error("counter field not zero outside test");
   a_tdata_zero_off: assert property (
      reg_rd && reg_addr == `VCW_OFF_TDATA && !tme_q |=> reg_rdata == 32'h0)
      else $error("test data readable outside test");
   a_test_stops_mem: assert property (
      tme_q [*3] |-> !mem_valid) else $error("memory word offered in test mode");
   a_mem_aligned: assert property (
      mem_valid |-> mem_addr[1:0] == 2'h0) else $error("memory address not word aligned");
   a_mem_holds: assert property (
      mem_valid && !mem_ack && !tme_q |=> $stable(mem_addr) && $stable(mem_data))
      else $error("memory word changed before ack");
   a_mem_steps: assert property (
      mem_valid && mem_ack && !tme_q |=> !mem_valid || mem_addr == $past(mem_addr) + 32'h4)
      else $error("memory address did not step by four");
   a_req_at_thr: assert property (
      mem_valid && thr_q == 5'h01 && $past(thr_q) == 5'h01 |-> mem_req)
      else $error("memory request missing at threshold");
endmodule

bind vcw_capture vcw_capture_chk i_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .strap_data_pins(strap_data_pins), .mem_req(mem_req), .mem_valid(mem_valid),
   .mem_addr(mem_addr),
   .mem_data(mem_data), .mem_ack(mem_ack), .irq(irq));

// ==== sim/vcw_capture_tb_top.sv ====
// Purpose: Self-checking bench of the capture window block
// Assumes: Syncs active low as after reset; memory side answered here
// Notes: Buffer depth cut to 8 so the test data walk stays short
`timescale 1ns/1ns
`include "vcw_params.svh"
module vcw_capture_tb_top;
   import vcw_pkg::*;
   localparam int DP = 8;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] reg_addr = 12'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic fdone = 1'b0;
   logic ovs = 1'b0;
   logic mem_ack = 1'b0;
   logic [3:0] strap = 4'h5;
   logic [31:0] reg_rdata;
   logic vclk;
   logic vs;
   logic hs;
   logic [7:0] dat;
   logic mem_valid;
   logic irq;
   logic [31:0] mem_addr;
   logic [31:0] mem_data;
   logic [31:0] rs = 32'h5;
   logic [31:0] ra = 32'h5;
   logic [31:0] v;
   logic [31:0] b0;
   logic [31:0] b1;
   logic [31:0] tw[DP];
   logic [7:0] eb[$];
   logic [63:0] got[$];
   int n_fail = 0;
   int checked = 0;

   always #20 clk = ~clk;

   vcw_capture #(.DEPTH(DP)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .vid_clk(vclk), .vertical_sync_in(vs), .horizontal_sync_in(hs), .vid_data(dat),
      .strap_data_pins(strap), .filter_done(fdone), .out_vsync(ovs), .mem_req(),
      .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_data(mem_data), .mem_ack(mem_ack),
      .irq(irq));
   vcw_src_model i_src (.vclk(vclk), .vs(vs), .hs(hs), .dat(dat));

   // ==========================================================
   // Helpers
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Down-scaler: a unit survives when the accumulator wraps
   function automatic bit keep(inout int acc, input int o, input int s);
      if (o >= s) return 1'b1;
      acc += o;
      if (acc < s) return 1'b0;
      acc -= s;
      return 1'b1;
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge clk);
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Memory takes words at random, so the block must hold each one meanwhile
   always @(posedge clk) begin
      if (mem_valid && mem_ack) begin
         got.push_back({mem_addr, mem_data});
      end
      ra = nx(ra);
      mem_ack <= mem_valid && ra[0];
   end

   // One frame through crop and scalers, then words and flags compared
   task automatic run(input int nl, np, xf, xl, yf, yl, w, h, input logic [31:0] base);
      int av;
      int ah;
      logic [7:0] sd;
      rs = nx(rs);
      sd = rs[7:0];
      eb.delete();
      got.delete();
      wr(`VCW_OFF_XWIN, 32'((xl << 20) | (xf << 4)));
      wr(`VCW_OFF_YWIN, 32'((yl << 20) | (yf << 4)));
      wr(`VCW_OFF_SIZE, 32'((w << 20) | (h << 4)));
      av = 0;
      for (int l = yf; l <= yl; l++) begin
         if (!keep(av, h, yl - yf + 1)) continue;
         ah = 0;
         for (int p = xf; p <= xl; p++) begin
            if (keep(ah, w, xl - xf + 1)) eb.push_back(sd + 8'(l * 16 + p));
         end
      end
      i_src.frame(nl, np, sd);
      v = 32'h0;
      for (int i = 0; i < 300 && v[31] !== 1'b1; i++) rd(`VCW_OFF_IRQ);
      chk("flags", v & 32'hA0000000, 32'hA0000000);
      chk("irq_cap", {31'h0, irq}, 32'h1);
      chk("words", 32'(got.size()), 32'(eb.size() / 4));
      for (int i = 0; i < eb.size() / 4; i++) begin
         chk("maddr", got[i][63:32], base + 32'(4 * i));
         chk("mdata", got[i][31:0], {eb[4*i+3], eb[4*i+2], eb[4*i+1], eb[4*i]});
      end
      wr(`VCW_OFF_IRQ, 32'hF0800000);
      rd(`VCW_OFF_IRQ);
      chk("flag_clr", v, 32'h00800000);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`VCW_OFF_IRQ);
      chk("irq_reset", v, 32'h0);
      rd(`VCW_OFF_CTRL);
      chk("ctrl_reset", v, `VCW_CTRL_RST);
      wr(12'h100, 32'hFFFFFFFF);
      rd(12'h100);
      chk("unmapped", v, 32'h0);
      for (int i = 0; i < 8; i++) begin
         rs = nx(rs);
         wr(`VCW_OFF_YWIN + 12'(4 * (i % 4)), (i == 0) ? 32'hFFFFFFFF : rs);
         rd(`VCW_OFF_YWIN + 12'(4 * (i % 4)));
         chk("reg", v, reg_wdata & ((i % 4 < 2) ? `VCW_YWIN_WMASK : `VCW_FB_WMASK));
      end
      wr(`VCW_OFF_TEST, rs & 32'hFFFFF7FF);
      rd(`VCW_OFF_TEST);
      chk("test", v, (rs & 32'h0000F000) | {28'h0, strap});
      rd(`VCW_OFF_TDATA);
      chk("tdata_off", v, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(`VCW_OFF_TEST, 32'h800 | (32'h1000 << i));
         rd(`VCW_OFF_TEST);
         chk("tsel", v & 32'hFFFF, 32'h800 | (32'h1000 << i) | {28'h0, strap});
      end
      for (int i = 0; i < 2 * DP; i++) begin
         if (i < DP) begin
            rs = nx(rs);
            tw[i] = rs;
            wr(`VCW_OFF_TDATA, rs);
         end else begin
            rd(`VCW_OFF_TDATA);
            chk("tdata", v, tw[i - DP]);
         end
      end
      wr(`VCW_OFF_TEST, 32'h0);
      // Each source pulsed with only the other enable set, then its own
      for (int k = 0; k < 2; k++) begin
         wr(`VCW_OFF_IRQ, (k == 0) ? 32'h00400000 : 32'h00100000);
         fdone <= (k == 0);
         ovs <= (k == 1);
         @(posedge clk);
         fdone <= 1'b0;
         ovs <= 1'b0;
         rd(`VCW_OFF_IRQ);
         chk("flag", v & 32'hF0000000, 32'h10000000 << (2 * k));
         chk("irq_other", {31'h0, irq}, 32'h0);
         wr(`VCW_OFF_IRQ, 32'h00100000 << (2 * k));
         #1 chk("irq_own", {31'h0, irq}, 32'h1);
         wr(`VCW_OFF_ICLR, 32'h10000000 << (2 * k));
         rd(`VCW_OFF_IRQ);
         chk("clear", v, 32'h00100000 << (2 * k));
         #1 chk("irq_clr", {31'h0, irq}, 32'h0);
      end
      rs = nx(rs);
      b0 = rs & 32'hFFFFFFFC;
      wr(`VCW_OFF_FB0, b0);
      rs = nx(rs);
      b1 = rs & 32'hFFFFFFFC;
      wr(`VCW_OFF_FB1, b1);
      wr(`VCW_OFF_CTRL, 32'h81000008);
      wr(`VCW_OFF_IRQ, 32'h00800000);
      run(2, 8, 0, 7, 1, 2, 8, 2, b0);
      rd(`VCW_OFF_CTRL);
      chk("bufsel", v & 32'h02000000, 32'h02000000);
      run(5, 10, 2, 9, 2, 5, 4, 2, b1);
      tally_and_finish();
   end

   // Watchdog well beyond the thousand or so cycles the sequence needs
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end
endmodule
